// ===== udrt_pkg.sv
/*
 * Shared constants of the up/down reload timer with clock output:
 * register offsets, field positions, reset values and divider ratios.
 * Assumes an APB slave with a byte address of at least eight bits.
 */
package udrt_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_CONTROL    = 8'h00;
	localparam logic [7:0] ADDR_MODE       = 8'h04;
	localparam logic [7:0] ADDR_COUNT_LOW  = 8'h08;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'h10;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h14;

	// ****************************************************************
	// Field positions in second_timer_control
	// ****************************************************************
	localparam int CTRL_OVERFLOW_BIT = 7;
	localparam int CTRL_TOGGLE_BIT   = 6;
	localparam int CTRL_RUN_BIT      = 2;
	localparam int CTRL_SOURCE_BIT   = 1;

	// ****************************************************************
	// Field positions in second_timer_mode_reg
	// ****************************************************************
	localparam int MODE_CLKOUT_BIT = 1;
	localparam int MODE_DOWN_BIT   = 0;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] RELOAD_RESET  = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int TIMER_DIVIDE  = 6;
	localparam int CLKOUT_DIVIDE = 2;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam logic [7:0]  BYTE_TOP  = 8'hFF;

endpackage

// ===== udrt_divider.sv
/*
 * Divider that issues a one-cycle enable pulse every DIVIDE cycles.
 * Assumes the enable input stays high while the pulses are wanted;
 * dropping it restarts the phase.
 */
`timescale 1ns/10ps

module udrt_divider #(
	parameter int DIVIDE = 6
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	output logic      tick
);

	localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

	logic [CW-1:0] phase;
	wire  logic    at_last;
	wire  logic [CW-1:0] next_phase;

	assign at_last    = (phase == LAST);
	assign next_phase = at_last ? '0 : phase + CW'(1);
	assign tick       = enable & at_last;

	// Restarting on disable gives software a fixed delay to the first step.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= '0;
		end else if (!enable) begin
			phase <= '0;
		end else begin
			phase <= next_phase;
		end
	end

endmodule

// ===== udrt_edge_detect.sv
/*
 * Falling-edge detector for the external count pin.
 * Assumes the pin level is already synchronous to pclk.
 */
`timescale 1ns/10ps

module udrt_edge_detect (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic level,
	output logic      fall
);

	logic previous;

	assign fall = previous & ~level;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			previous <= 1'b0;
		end else begin
			previous <= level;
		end
	end

endmodule

// ===== udrt_timer.sv
/*
 * Sixteen-bit up/down auto-reload timer with a clock-output mode,
 * reached over APB with zero wait states.
 * Assumes pclk is the timer input clock and all pin inputs are
 * synchronous to it.
 */
// Notes on behaviour
// - Count held as two cascaded bytes.
// - Source is clock by six or pin.
// - Counts only while the run bit is set.
// - Down enable lets the pin pick direction.
// - Up count wraps past FFFF, sets flag.
// - Up overflow reloads count from reload pair.
// - Down underflow when count equals reload value.
// - Underflow sets flag and loads FFFF.
// - Extension flag toggles per wrap only with down enable set, no request.
// - Clock output is a square wave.
// - Clock mode steps at clock by two.
// - Clock mode counts up, reloads each overflow.
// - No interrupt request in clock mode.
// - Output frequency is clock over 4(65536-reload).
// - Waveform drives the external count pin.
// - Overflow tick shared for baud use too.
// - Overflow flag stays until software clears it.
`timescale 1ns/10ps

module udrt_timer #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  external_count_pin_in,
	output logic                       external_count_pin_out,
	output logic                       external_count_pin_oe_n,
	input  wire logic                  direction_input_pin,
	output logic                       interrupt_request,
	output logic                       reload_tick
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0] count_low_byte;
	logic [7:0] count_high_byte;
	logic [7:0] reload_low_byte;
	logic [7:0] reload_high_byte;
	logic       overflow_flag;
	logic       toggle_extension_flag;
	logic       run_control_bit;
	logic       count_source_select;
	logic       clock_output_enable;
	logic       down_count_enable;
	logic       clock_out_level;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire logic [7:0] addr;
	wire logic       setup;
	wire logic       access;
	wire logic       wr;
	wire logic       hit_control;
	wire logic       hit_mode;
	wire logic       hit_count_low;
	wire logic       hit_count_high;
	wire logic       hit_reload_low;
	wire logic       hit_reload_high;
	wire logic       mapped;
	wire logic [7:0] wbyte;

	assign addr            = 8'(paddr);
	assign setup           = psel & ~penable;
	assign access          = psel & penable;
	assign wr              = access & pwrite;
	assign wbyte           = pwdata[7:0];
	assign hit_control     = (addr == udrt_pkg::ADDR_CONTROL);
	assign hit_mode        = (addr == udrt_pkg::ADDR_MODE);
	assign hit_count_low   = (addr == udrt_pkg::ADDR_COUNT_LOW);
	assign hit_count_high  = (addr == udrt_pkg::ADDR_COUNT_HIGH);
	assign hit_reload_low  = (addr == udrt_pkg::ADDR_RELOAD_LOW);
	assign hit_reload_high = (addr == udrt_pkg::ADDR_RELOAD_HIGH);
	assign mapped = hit_control | hit_mode | hit_count_low |
		hit_count_high | hit_reload_low | hit_reload_high;
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// ****************************************************************
	// Read data
	// ****************************************************************
	wire logic [7:0] control_view;
	wire logic [7:0] mode_view;
	wire logic [7:0] read_byte;

	assign control_view = {overflow_flag, toggle_extension_flag, 3'b000,
		run_control_bit, count_source_select, 1'b0};
	assign mode_view = {6'b000000, clock_output_enable, down_count_enable};
	assign read_byte = hit_control     ? control_view :
	                   hit_mode        ? mode_view :
	                   hit_count_low   ? count_low_byte :
	                   hit_count_high  ? count_high_byte :
	                   hit_reload_low  ? reload_low_byte :
	                   hit_reload_high ? reload_high_byte : 8'h00;

	// Read data is captured in the setup cycle and held for the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= {24'h000000, read_byte};
		end
	end

	// ****************************************************************
	// Step sources
	// ****************************************************************
	wire logic timer_tick;
	wire logic clkout_tick;
	wire logic pin_fall;
	wire logic step;

	udrt_divider #(
		.DIVIDE (udrt_pkg::TIMER_DIVIDE)
	) u_timer_div (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (run_control_bit),
		.tick    (timer_tick)
	);

	udrt_divider #(
		.DIVIDE (udrt_pkg::CLKOUT_DIVIDE)
	) u_clkout_div (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (run_control_bit),
		.tick    (clkout_tick)
	);

	udrt_edge_detect u_pin_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (external_count_pin_in),
		.fall    (pin_fall)
	);

	// Clock mode takes precedence so a stale source bit cannot slow it.
	assign step = run_control_bit & (clock_output_enable ? clkout_tick :
		(count_source_select ? pin_fall : timer_tick));

	// ****************************************************************
	// Count arithmetic
	// ****************************************************************
	wire logic [15:0] count_value;
	wire logic [15:0] reload_value;
	wire logic        count_up;
	wire logic        overflow_up;
	wire logic        underflow_down;
	wire logic        wrap;
	wire logic        low_carry;
	wire logic        low_borrow;
	wire logic [7:0]  low_inc;
	wire logic [7:0]  high_inc;
	wire logic [7:0]  low_dec;
	wire logic [7:0]  high_dec;
	wire logic [7:0]  next_low_step;
	wire logic [7:0]  next_high_step;

	assign count_value  = {count_high_byte, count_low_byte};
	assign reload_value = {reload_high_byte, reload_low_byte};

	// Clock mode always counts up whatever the direction pin says.
	assign count_up = clock_output_enable | ~down_count_enable |
		direction_input_pin;

	assign overflow_up    = count_up & (count_value == udrt_pkg::COUNT_TOP);
	assign underflow_down = ~count_up & (count_value == reload_value);
	assign wrap           = step & (overflow_up | underflow_down);

	// Except when a wrap loads it, the high byte moves only on a carry or borrow out of the low byte.
	assign low_carry  = (count_low_byte == udrt_pkg::BYTE_TOP);
	assign low_borrow = (count_low_byte == 8'h00);
	assign low_inc    = count_low_byte + 8'h01;
	assign high_inc   = low_carry ? count_high_byte + 8'h01 : count_high_byte;
	assign low_dec    = count_low_byte - 8'h01;
	assign high_dec   = low_borrow ? count_high_byte - 8'h01 : count_high_byte;

	assign next_low_step  = overflow_up    ? reload_low_byte :
	                        underflow_down ? udrt_pkg::BYTE_TOP :
	                        count_up       ? low_inc : low_dec;
	assign next_high_step = overflow_up    ? reload_high_byte :
	                        underflow_down ? udrt_pkg::BYTE_TOP :
	                        count_up       ? high_inc : high_dec;

	// ****************************************************************
	// Count registers
	// ****************************************************************
	// A software write to a count byte wins over a step in that cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_low_byte <= udrt_pkg::COUNT_RESET;
		end else if (wr && hit_count_low) begin
			count_low_byte <= wbyte;
		end else if (step) begin
			count_low_byte <= next_low_step;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_high_byte <= udrt_pkg::COUNT_RESET;
		end else if (wr && hit_count_high) begin
			count_high_byte <= wbyte;
		end else if (step) begin
			count_high_byte <= next_high_step;
		end
	end

	// ****************************************************************
	// Reload and mode registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_low_byte  <= udrt_pkg::RELOAD_RESET;
			reload_high_byte <= udrt_pkg::RELOAD_RESET;
		end else begin
			if (wr && hit_reload_low) begin
				reload_low_byte <= wbyte;
			end
			if (wr && hit_reload_high) begin
				reload_high_byte <= wbyte;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_output_enable <= udrt_pkg::MODE_RESET[udrt_pkg::MODE_CLKOUT_BIT];
			down_count_enable   <= udrt_pkg::MODE_RESET[udrt_pkg::MODE_DOWN_BIT];
		end else if (wr && hit_mode) begin
			clock_output_enable <= wbyte[udrt_pkg::MODE_CLKOUT_BIT];
			down_count_enable   <= wbyte[udrt_pkg::MODE_DOWN_BIT];
		end
	end

	// ****************************************************************
	// Control register and flags
	// ****************************************************************
	wire logic set_overflow;
	wire logic flip_extension;
	wire logic ctrl_wr;
	wire logic next_overflow_flag;
	wire logic next_toggle_flag;

	assign ctrl_wr        = wr & hit_control;
	assign set_overflow   = wrap & ~clock_output_enable;
	assign flip_extension = wrap & down_count_enable & ~clock_output_enable;

	// A hardware event in the cycle of a software clear is kept.
	assign next_overflow_flag = set_overflow ? 1'b1 :
		(ctrl_wr ? wbyte[udrt_pkg::CTRL_OVERFLOW_BIT] : overflow_flag);
	assign next_toggle_flag = flip_extension ? ~toggle_extension_flag :
		(ctrl_wr ? wbyte[udrt_pkg::CTRL_TOGGLE_BIT] : toggle_extension_flag);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag <= udrt_pkg::CONTROL_RESET[udrt_pkg::CTRL_OVERFLOW_BIT];
			toggle_extension_flag <=
				udrt_pkg::CONTROL_RESET[udrt_pkg::CTRL_TOGGLE_BIT];
		end else begin
			overflow_flag         <= next_overflow_flag;
			toggle_extension_flag <= next_toggle_flag;
		end
	end

	// Software must program mode, reload and count before setting run.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_control_bit     <= udrt_pkg::CONTROL_RESET[udrt_pkg::CTRL_RUN_BIT];
			count_source_select <=
				udrt_pkg::CONTROL_RESET[udrt_pkg::CTRL_SOURCE_BIT];
		end else if (ctrl_wr) begin
			run_control_bit     <= wbyte[udrt_pkg::CTRL_RUN_BIT];
			count_source_select <= wbyte[udrt_pkg::CTRL_SOURCE_BIT];
		end
	end

	// ****************************************************************
	// Clock output and shared overflow tick
	// ****************************************************************
	// One inversion per overflow gives a period of four times the span
	// from reload to the top, counted in input clock cycles.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_out_level <= 1'b0;
		end else if (wrap && clock_output_enable) begin
			clock_out_level <= ~clock_out_level;
		end
	end

	// The same overflow tick serves a serial baud divider elsewhere, so
	// baud rate and clock output cannot be set independently.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_tick <= 1'b0;
		end else begin
			reload_tick <= wrap;
		end
	end

	assign external_count_pin_out  = clock_out_level;
	assign external_count_pin_oe_n = ~clock_output_enable;
	assign interrupt_request       = overflow_flag;

endmodule

// ===== udrt_pins_model.sv
/*
 * Far-side model of the count, direction and clock-out pins.
 * Assumes the bench calls its tasks from the pclk domain.
 */
`timescale 1ns/10ps

module udrt_pins_model (
	input  wire logic pclk,
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      pin_wire,
	output logic      dir_level
);
	logic drive_level;

	initial begin
		drive_level = 1'b1;
		dir_level = 1'b1;
	end

	// The pin idles high; the timer owns it only in clock-out mode.
	assign pin_wire = pin_oe_n ? drive_level : pin_out;

	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge pclk) drive_level <= 1'b0;
			repeat (2) @(posedge pclk);
			drive_level <= 1'b1;
			repeat (2) @(posedge pclk);
		end
	endtask

	task automatic set_dir(input logic up);
		@(posedge pclk) dir_level <= up;
	endtask
endmodule

// ===== udrt_timer_monitor.sv
/*
 * Port checker for the timer; shadows mode and control writes.
 * Assumes it is bound into udrt_timer.
 */
`timescale 1ns/10ps

module udrt_timer_monitor #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  external_count_pin_in,
	input wire logic                  external_count_pin_out,
	input wire logic                  external_count_pin_oe_n,
	input wire logic                  direction_input_pin,
	input wire logic                  interrupt_request,
	input wire logic                  reload_tick
);
	localparam int MC = udrt_pkg::MODE_CLKOUT_BIT;
	wire wr = psel && penable && pwrite;
	wire wr_ctl = wr && paddr[7:0] == udrt_pkg::ADDR_CONTROL;
	wire wr_mode = wr && paddr[7:0] == udrt_pkg::ADDR_MODE;
	logic clk_m;
	logic run_m;
	logic src_m;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_m <= 1'b0;
			run_m <= 1'b0;
			src_m <= 1'b0;
		end else begin
			if (wr_mode)
				clk_m <= pwdata[MC];
			if (wr_ctl) begin
				run_m <= pwdata[udrt_pkg::CTRL_RUN_BIT];
				src_m <= pwdata[udrt_pkg::CTRL_SOURCE_BIT];
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ********
	// Properties
	// ********
	property p_oe;
		wr_mode |=> external_count_pin_oe_n == !$past(pwdata[MC]);
	endproperty
	a_oe: assert property (p_oe) else $error("oe_n off mode");
	property p_noirq;
		clk_m && $past(clk_m) && !$past(wr_ctl)
			|-> !$rose(interrupt_request);
	endproperty
	a_noirq: assert property (p_noirq) else $error("irq in clkout");
	property p_pin;
		$changed(external_count_pin_out) && clk_m |-> ##[0:1] reload_tick;
	endproperty
	a_pin: assert property (p_pin) else $error("pin flip no wrap");
	property p_rise;
		$rose(interrupt_request) && !$past(wr_ctl) |-> ##[0:1] reload_tick;
	endproperty
	a_rise: assert property (p_rise) else $error("irq no wrap");
	property p_hold;
		$fell(interrupt_request) |-> $past(wr_ctl);
	endproperty
	a_hold: assert property (p_hold) else $error("flag self clear");
	property p_fast;
		reload_tick && clk_m |=> !reload_tick;
	endproperty
	a_fast: assert property (p_fast) else $error("clkout step");
	property p_div;
		reload_tick && !src_m && !clk_m && !$past(clk_m)
			|=> !reload_tick [*5];
	endproperty
	a_div: assert property (p_div) else $error("divide by six");
	property p_run;
		(!run_m) [*3] |-> !reload_tick;
	endproperty
	a_run: assert property (p_run) else $error("wrap while off");
	// Every access completes at once, reads show one byte, and only
	// addresses outside the six aligned registers report an error.
	property p_bus;
		psel && penable |-> pready && prdata[31:8] == 24'h000000 &&
			pslverr == !(paddr[7:0] <= udrt_pkg::ADDR_RELOAD_HIGH &&
			paddr[1:0] == 2'b00);
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer");
endmodule

bind udrt_timer udrt_timer_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon_u (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.external_count_pin_in(external_count_pin_in),
	.external_count_pin_out(external_count_pin_out),
	.external_count_pin_oe_n(external_count_pin_oe_n),
	.direction_input_pin(direction_input_pin),
	.interrupt_request(interrupt_request),
	.reload_tick(reload_tick)
);

// ===== updown_reload_timer_clockout_bench.sv
/*
 * Directed APB bench for the up/down reload timer.
 * Assumes the pin model and bound checker are compiled alongside.
 */
`timescale 1ns/10ps

module updown_reload_timer_clockout_bench;
	localparam logic [7:0] A_CTL = udrt_pkg::ADDR_CONTROL;
	localparam logic [7:0] A_MOD = udrt_pkg::ADDR_MODE;
	localparam logic [7:0] A_CL = udrt_pkg::ADDR_COUNT_LOW;
	localparam logic [7:0] A_CH = udrt_pkg::ADDR_COUNT_HIGH;
	localparam logic [7:0] A_RL = udrt_pkg::ADDR_RELOAD_LOW;
	localparam logic [7:0] A_RH = udrt_pkg::ADDR_RELOAD_HIGH;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin_wire;
	logic        pin_out;
	logic        oe_n;
	logic        dir;
	logic        irq;
	logic        tick;
	logic [31:0] q;
	logic        e;
	int          err_total;
	int          check_count;
	int          n;
	int          cyc;
	int          t0;
	int          t1;
	int          half;

	udrt_timer dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_count_pin_in(pin_wire),
		.external_count_pin_out(pin_out),
		.external_count_pin_oe_n(oe_n),
		.direction_input_pin(dir),
		.interrupt_request(irq), .reload_tick(tick)
	);
	udrt_pins_model pins_u (.pclk(pclk), .pin_out(pin_out),
		.pin_oe_n(oe_n), .pin_wire(pin_wire), .dir_level(dir));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;

	task test_done;
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Holds the request until pready is seen high at a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		// Upper data bits carry junk so that their being ignored is seen.
		pwdata <= {a, a, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	task wait_lvl(input logic v, input int lim);
		n = 0;
		while (((v ? irq : pin_wire) !== v) && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask

	task wait_pin(input logic v);
		n = 0;
		while (pin_wire !== v && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 400) begin
			err_total++;
			$display("[FAIL] %0t pin level not reached", $time);
		end
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		err_total = 0;
		check_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_CTL, 32'h00000000);
		rd(A_CH, 32'h00000000);
		rd(8'h40, 32'h00000000);
		chk({31'h0, e}, 32'h00000001);
		wr(A_RL, 8'h34);
		wr(A_RH, 8'h12);
		wr(A_CL, 8'hFE);
		wr(A_CH, 8'hFF);
		wr(A_CTL, 8'h04);
		wait_lvl(1'b1, 40);
		chk({31'h0, n >= 12 && n <= 14}, 32'h00000001);
		wr(A_CTL, 8'h80);
		repeat (30) @(posedge pclk);
		chk({31'h0, irq}, 32'h00000001);
		rd(A_CL, 32'h00000034);
		rd(A_CH, 32'h00000012);
		wr(A_CTL, 8'h00);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h00000000);
		wr(A_CL, 8'hFF);
		wr(A_CH, 8'h00);
		wr(A_CTL, 8'h04);
		repeat (8) @(posedge pclk);
		wr(A_CTL, 8'h00);
		rd(A_CH, 32'h00000001);
		rd(A_CL, 32'h00000000);
		wr(A_CTL, 8'h06);
		pins_u.pulses(3);
		wr(A_CTL, 8'h00);
		pins_u.pulses(2);
		rd(A_CL, 32'h00000003);
		wr(A_MOD, 8'h01);
		wr(A_RL, 8'h10);
		wr(A_RH, 8'h00);
		wr(A_CL, 8'h11);
		wr(A_CH, 8'h00);
		pins_u.set_dir(1'b0);
		wr(A_CTL, 8'h06);
		pins_u.pulses(2);
		rd(A_CH, 32'h000000FF);
		rd(A_CL, 32'h000000FF);
		rd(A_CTL, 32'h000000C6);
		pins_u.set_dir(1'b1);
		pins_u.pulses(1);
		rd(A_CL, 32'h00000010);
		rd(A_CTL, 32'h00000086);
		wr(A_CTL, 8'h00);
		// Clock-out is set up in the order that software must keep.
		wr(A_MOD, 8'h02);
		wr(A_RL, 8'hF0);
		wr(A_RH, 8'hFF);
		wr(A_CL, 8'hF0);
		wr(A_CH, 8'hFF);
		wr(A_CTL, 8'h04);
		half = udrt_pkg::CLKOUT_DIVIDE * (32'h00010000 - 32'h0000FFF0);
		// Timing starts at a rising edge of the pin, never mid-level.
		wait_pin(1'b0);
		wait_pin(1'b1);
		t0 = cyc;
		wait_pin(1'b0);
		t1 = cyc;
		wait_pin(1'b1);
		chk(t1 - t0, half);
		chk(cyc - t0, 2 * half);
		chk({31'h0, oe_n}, 32'h00000000);
		chk({31'h0, irq}, 32'h00000000);
		test_done;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		test_done;
	end
endmodule
